// file: hdl/scbi_irq_flags.sv
`timescale 1ns/1ps
`default_nettype none
module scbi_irq_flags #(
  parameter int          W     = 32,
  parameter logic [31:0] VALID = 32'hFFFF_FFFF
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_status,
  input  wire logic [W-1:0] i_event,
  input  wire logic [W-1:0] i_clear,
  output logic      [W-1:0] o_flags
);

  // ==========================================================================
  // per-bit rising edge flag
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      if (VALID[g]) begin : g_on
        logic prev;
        wire  set_now = (i_status[g] & ~prev) | i_event[g];
        always_ff @(posedge i_clk or negedge i_rst_n) begin
          if (!i_rst_n) begin
            prev       <= 1'b0;
            o_flags[g] <= 1'b0;
          end else begin
            prev <= i_status[g];
            // set beats clear so a coincident edge is kept
            if (set_now) begin
              o_flags[g] <= 1'b1;
            end else if (i_clear[g]) begin
              o_flags[g] <= 1'b0;
            end
          end
        end
      end else begin : g_off
        assign o_flags[g] = 1'b0;
      end
    end
  endgenerate

endmodule // scbi_irq_flags
`default_nettype wire

// file: hdl/scbi_pkg.sv
package scbi_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ             = 100_000_000;
  localparam int unsigned SYSRC_HZ           = 115_000;
  localparam int unsigned SYSRC_START_OSC    = 3;
  localparam int unsigned SYSRC_START_CYC    =
    SYSRC_START_OSC * ((CLK_HZ + SYSRC_HZ - 1) / SYSRC_HZ);
  localparam int unsigned LFRC_HZ            = 32_768;
  localparam int unsigned LF_DIV_CYC         = CLK_HZ / LFRC_HZ;
  localparam int unsigned SM_ON_TICKS        = 2;
  localparam int unsigned BR_WRITE_CYC       = 4;
  localparam int unsigned ADC_TEMP_CHANNEL   = 7;

  // ==========================================================================
  // register offsets
  localparam logic [9:0] OFS_IRQ_ENABLE  = 10'h000;
  localparam logic [9:0] OFS_IRQ_DISABLE = 10'h004;
  localparam logic [9:0] OFS_IRQ_MASK    = 10'h008;
  localparam logic [9:0] OFS_IRQ_STATUS  = 10'h00C;
  localparam logic [9:0] OFS_IRQ_CLEAR   = 10'h010;
  localparam logic [9:0] OFS_PWR_STATUS  = 10'h014;
  localparam logic [9:0] OFS_UNLOCK      = 10'h018;
  localparam logic [9:0] OFS_SYSRC_TRIM  = 10'h048;
  localparam logic [9:0] OFS_SUPPLY_MON  = 10'h04C;
  localparam logic [9:0] OFS_TEMP_SENSOR = 10'h050;
  localparam logic [9:0] OFS_FAST_RC     = 10'h058;
  localparam logic [9:0] OFS_RETAIN_0    = 10'h05C;
  localparam logic [9:0] OFS_LOW_RC      = 10'h06C;

  // ==========================================================================
  // fields and reset values
  localparam int unsigned BIT_AE         = 31;
  localparam int unsigned BIT_RETAIN_RDY = 16;
  localparam int unsigned BIT_RETAIN_VAL = 17;
  localparam int unsigned BIT_FLL_LO     = 8;
  localparam int unsigned BIT_BROWNOUT   = 7;
  localparam int unsigned BIT_SM_DETECT  = 6;
  localparam int unsigned BIT_REG_OK     = 5;
  localparam int unsigned BIT_MAIN_OSC   = 1;
  localparam int unsigned BIT_XTAL32     = 0;
  localparam logic [31:0] IRQ_VALID      = 32'h8001_FFE3;
  localparam int unsigned SM_EN_BIT      = 0;
  localparam int unsigned SM_FORCE_BIT   = 1;
  localparam int unsigned SM_RESET_BIT   = 2;
  localparam int unsigned SM_SEL_LO      = 8;
  localparam int unsigned SM_SEL_W       = 4;
  localparam int unsigned EN_BIT         = 0;
  localparam int unsigned UNLOCK_KEY_LO  = 24;
  localparam logic [7:0]  UNLOCK_KEY     = 8'hAA;
  localparam logic [31:0] SM_RESET_VAL   = 32'h0000_0001;
  localparam logic        LOW_RC_EN_RST  = 1'b1;

  typedef enum logic [2:0] {
    SLP_RUN      = 3'b000,
    SLP_IDLE     = 3'b001,
    SLP_FROZEN   = 3'b010,
    SLP_STANDBY  = 3'b011,
    SLP_STOP     = 3'b100,
    SLP_DEEPSTOP = 3'b101,
    SLP_STATIC   = 3'b110
  } scbi_sleep_t;

  typedef enum logic {
    BK_IDLE = 1'b0,
    BK_BUSY = 1'b1
  } scbi_bk_t;

endpackage

// file: hdl/scbi_sm_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module scbi_sm_sampler #(
  parameter int LF_DIV   = 3051,
  parameter int ON_TICKS = 2,
  parameter int SEL_W    = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_enable,
  input  wire logic             i_sampling,
  input  wire logic [SEL_W-1:0] i_sel,
  input  wire logic             i_supply_low,
  output logic                  o_power,
  output logic                  o_detect
);

  // ==========================================================================
  // low-frequency tick and sampling period
  logic [15:0] div_cnt;
  logic [23:0] per_cnt;
  wire         lf_tick  = (div_cnt == 16'(LF_DIV - 1));
  wire  [23:0] per_last = (24'h00_0010 << i_sel) - 24'h00_0001;
  wire         in_on    = (per_cnt < 24'(ON_TICKS));
  wire         last_on  = (per_cnt == 24'(ON_TICKS - 1)) & lf_tick;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt  <= 16'h0000;
      per_cnt  <= 24'h00_0000;
      o_power  <= 1'b0;
      o_detect <= 1'b0;
    end else if (!i_enable) begin
      div_cnt  <= 16'h0000;
      per_cnt  <= 24'h00_0000;
      o_power  <= 1'b0;
      o_detect <= 1'b0;
    end else if (!i_sampling) begin
      div_cnt  <= 16'h0000;
      per_cnt  <= 24'h00_0000;
      o_power  <= 1'b1;
      o_detect <= i_supply_low;
    end else begin
      div_cnt <= lf_tick ? 16'h0000 : div_cnt + 16'h0001;
      if (lf_tick) begin
        per_cnt <= (per_cnt >= per_last) ? 24'h00_0000 : per_cnt + 24'h00_0001;
      end
      // short measurement window, then long off time
      o_power <= in_on;
      if (last_on) begin
        o_detect <= i_supply_low;
      end
    end
  end

endmodule // scbi_sm_sampler
`default_nettype wire

// file: hdl/scbi_top.sv
`timescale 1ns/1ps
`default_nettype none
module scbi_top #(
  parameter int TRIM_W       = 8,
  parameter int LF_DIV       = scbi_pkg::LF_DIV_CYC,
  parameter int SYSRC_START  = scbi_pkg::SYSRC_START_CYC,
  parameter int BR_WRITE     = scbi_pkg::BR_WRITE_CYC
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic              i_por_n,
  input  wire logic [9:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [2:0]        i_sleep_mode,
  input  wire logic [TRIM_W-1:0] i_fuse_trim,
  input  wire logic              i_pm_fast_rc_off,
  input  wire logic              i_pm_pad_ctrl_rc_out,
  input  wire logic              i_pad_func_rc,
  input  wire logic              i_supply_low,
  input  wire logic [7:0]        i_fll_status,
  input  wire logic              i_brownout_detect,
  input  wire logic              i_regulator_ok,
  input  wire logic              i_main_osc_ready,
  input  wire logic              i_xtal32_ready,
  output logic [31:0]            o_rdata,
  output logic                   o_irq,
  output logic                   o_sysrc_run,
  output logic                   o_sysrc_ready,
  output logic [TRIM_W-1:0]      o_sysrc_trim,
  output logic                   o_sm_power,
  output logic                   o_sm_reset_req,
  output logic                   o_low_rc_run,
  output logic                   o_low_rc_pad,
  output logic                   o_temp_sensor_en,
  output logic                   o_fast_rc_run
);

  // ==========================================================================
  // reset synchronisers
  logic rst_s1;
  logic rst_n;
  logic por_s1;
  logic por_n;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // power-on reset also forces the system reset via i_reset_n at board level
  always_ff @(posedge i_clk_sys or negedge i_por_n) begin
    if (!i_por_n) begin
      por_s1 <= 1'b0;
      por_n  <= 1'b0;
    end else begin
      por_s1 <= 1'b1;
      por_n  <= por_s1;
    end
  end

  // ==========================================================================
  // address decode
  wire        wr_ier    = i_wr & (i_addr == scbi_pkg::OFS_IRQ_ENABLE);
  wire        wr_idr    = i_wr & (i_addr == scbi_pkg::OFS_IRQ_DISABLE);
  wire        wr_icr    = i_wr & (i_addr == scbi_pkg::OFS_IRQ_CLEAR);
  wire        wr_unlock = i_wr & (i_addr == scbi_pkg::OFS_UNLOCK);
  wire        hit_trim  = (i_addr == scbi_pkg::OFS_SYSRC_TRIM);
  wire        hit_sm    = (i_addr == scbi_pkg::OFS_SUPPLY_MON);
  wire        wr_temp   = i_wr & (i_addr == scbi_pkg::OFS_TEMP_SENSOR);
  wire        wr_fast   = i_wr & (i_addr == scbi_pkg::OFS_FAST_RC);
  wire        wr_low    = i_wr & (i_addr == scbi_pkg::OFS_LOW_RC);
  wire [9:0]  bk_rel    = i_addr - scbi_pkg::OFS_RETAIN_0;
  wire        hit_bk    = (i_addr >= scbi_pkg::OFS_RETAIN_0) & (bk_rel < 10'h010)
                          & (bk_rel[1:0] == 2'b00);
  wire [1:0]  bk_idx    = bk_rel[3:2];

  // ==========================================================================
  // unlock: key in top byte, target offset in low bits, one access only
  logic       unlock_armed;
  logic [9:0] unlock_addr;
  wire        prot_wr   = i_wr & (hit_trim | hit_sm);
  wire        unlock_ok = unlock_armed & (unlock_addr == i_addr);
  wire        trim_wr   = i_wr & hit_trim & unlock_ok;
  wire        sm_wr     = i_wr & hit_sm & unlock_ok;
  wire        access_err = prot_wr & ~unlock_ok;
  wire        key_ok    = (i_wdata[scbi_pkg::UNLOCK_KEY_LO +: 8] == scbi_pkg::UNLOCK_KEY);

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      unlock_armed <= 1'b0;
      unlock_addr  <= 10'h000;
    end else if (wr_unlock) begin
      unlock_armed <= key_ok;
      unlock_addr  <= i_wdata[9:0];
    end else if (i_wr) begin
      unlock_armed <= 1'b0;
    end
  end

  // ==========================================================================
  // system RC: trim loaded from fuses once after power-on
  logic        trim_loaded;
  logic [11:0] sysrc_cnt;
  wire         sysrc_on = (i_sleep_mode != scbi_pkg::SLP_STATIC);

  always_ff @(posedge i_clk_sys or negedge por_n) begin
    if (!por_n) begin
      trim_loaded  <= 1'b0;
      o_sysrc_trim <= '0;
    end else if (!trim_loaded) begin
      trim_loaded  <= 1'b1;
      o_sysrc_trim <= i_fuse_trim;
    end else if (trim_wr) begin
      o_sysrc_trim <= i_wdata[TRIM_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sysrc_cnt     <= 12'h000;
      o_sysrc_run   <= 1'b0;
      o_sysrc_ready <= 1'b0;
    end else begin
      o_sysrc_run <= sysrc_on;
      if (!sysrc_on) begin
        sysrc_cnt     <= 12'h000;
        o_sysrc_ready <= 1'b0;
      end else if (sysrc_cnt != 12'(SYSRC_START)) begin
        sysrc_cnt <= sysrc_cnt + 12'h001;
      end else begin
        o_sysrc_ready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // supply monitor, oscillators, temperature sensor
  logic [31:0] sm_ctrl;
  logic        low_rc_en;
  logic        fast_rc_en;
  logic        sm_detect;
  logic        sm_power;
  wire         deep_sleep  = (i_sleep_mode == scbi_pkg::SLP_DEEPSTOP)
                             | (i_sleep_mode == scbi_pkg::SLP_STATIC);
  wire         sm_en       = sm_ctrl[scbi_pkg::SM_EN_BIT];
  wire         sm_sampling = sm_en & (sm_ctrl[scbi_pkg::SM_FORCE_BIT] | deep_sleep);
  wire [3:0]   sm_sel      = sm_ctrl[scbi_pkg::SM_SEL_LO +: scbi_pkg::SM_SEL_W];
  wire         low_rc_on   = low_rc_en | sm_sampling;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sm_ctrl          <= scbi_pkg::SM_RESET_VAL;
      low_rc_en        <= scbi_pkg::LOW_RC_EN_RST;
      fast_rc_en       <= 1'b0;
      o_temp_sensor_en <= 1'b0;
    end else begin
      if (sm_wr) begin
        sm_ctrl <= i_wdata;
      end
      if (wr_low) begin
        low_rc_en <= i_wdata[scbi_pkg::EN_BIT];
      end
      if (wr_fast) begin
        fast_rc_en <= i_wdata[scbi_pkg::EN_BIT];
      end
      if (wr_temp) begin
        o_temp_sensor_en <= i_wdata[scbi_pkg::EN_BIT];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_low_rc_run   <= 1'b0;
      o_low_rc_pad   <= 1'b0;
      o_fast_rc_run  <= 1'b0;
      o_sm_power     <= 1'b0;
      o_sm_reset_req <= 1'b0;
    end else begin
      o_low_rc_run   <= low_rc_on;
      o_low_rc_pad   <= low_rc_on & i_pm_pad_ctrl_rc_out & i_pad_func_rc;
      o_fast_rc_run  <= fast_rc_en & ~i_pm_fast_rc_off;
      o_sm_power     <= sm_power;
      o_sm_reset_req <= sm_detect & sm_ctrl[scbi_pkg::SM_RESET_BIT];
    end
  end

  scbi_sm_sampler #(
    .LF_DIV   (LF_DIV),
    .ON_TICKS (scbi_pkg::SM_ON_TICKS),
    .SEL_W    (scbi_pkg::SM_SEL_W)
  ) u_sampler (
    .i_clk        (i_clk_sys),
    .i_rst_n      (rst_n),
    .i_enable     (sm_en),
    .i_sampling   (sm_sampling),
    .i_sel        (sm_sel),
    .i_supply_low (i_supply_low),
    .o_power      (sm_power),
    .o_detect     (sm_detect)
  );

  // ==========================================================================
  // retained words: power-on reset only, write opens a busy window
  logic [31:0]       retained [4];
  logic              bk_done;
  logic              bk_open;
  scbi_pkg::scbi_bk_t bk_state;
  logic [7:0]        bk_cnt;
  wire               bk_ready  = (bk_state == scbi_pkg::BK_IDLE);
  wire               bk_wr     = i_wr & hit_bk & bk_ready;
  wire               bk_finish = (bk_state == scbi_pkg::BK_BUSY)
                                 & (bk_cnt == 8'(BR_WRITE - 1));
  wire               bk_valid  = bk_done & ~bk_open & bk_ready;

  always_ff @(posedge i_clk_sys or negedge por_n) begin
    if (!por_n) begin
      bk_done <= 1'b0;
      bk_open <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        retained[k] <= 32'h0000_0000;
      end
    end else begin
      if (bk_wr) begin
        retained[bk_idx] <= i_wdata;
        bk_open          <= 1'b1;
      end else if (bk_finish) begin
        bk_open <= 1'b0;
        bk_done <= 1'b1;
      end
    end
  end

  // a system reset mid-write leaves bk_open high, so valid stays low
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bk_state <= scbi_pkg::BK_IDLE;
      bk_cnt   <= 8'h00;
    end else begin
      case (bk_state)
        scbi_pkg::BK_IDLE: begin
          bk_cnt <= 8'h00;
          if (bk_wr) begin
            bk_state <= scbi_pkg::BK_BUSY;
          end
        end
        scbi_pkg::BK_BUSY: begin
          bk_cnt <= bk_cnt + 8'h01;
          if (bk_finish) begin
            bk_state <= scbi_pkg::BK_IDLE;
          end
        end
        default: begin
          bk_state <= scbi_pkg::BK_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // status and interrupt flags
  logic [31:0] irq_mask;
  logic [31:0] irq_flags;
  wire  [31:0] pwr_status = {14'h0000, bk_valid, bk_ready, i_fll_status,
                             i_brownout_detect, sm_detect, i_regulator_ok,
                             3'b000, i_main_osc_ready, i_xtal32_ready};
  wire  [31:0] irq_event  = {access_err, 31'h0000_0000};
  wire  [31:0] irq_clear  = wr_icr ? i_wdata : 32'h0000_0000;

  scbi_irq_flags #(
    .W     (32),
    .VALID (scbi_pkg::IRQ_VALID)
  ) u_flags (
    .i_clk    (i_clk_sys),
    .i_rst_n  (rst_n),
    .i_status (pwr_status & scbi_pkg::IRQ_VALID),
    .i_event  (irq_event),
    .i_clear  (irq_clear),
    .o_flags  (irq_flags)
  );

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 32'h0000_0000;
      o_irq    <= 1'b0;
    end else begin
      if (wr_ier) begin
        irq_mask <= irq_mask | (i_wdata & scbi_pkg::IRQ_VALID);
      end else if (wr_idr) begin
        irq_mask <= irq_mask & ~i_wdata;
      end
      o_irq <= |(irq_flags & irq_mask);
    end
  end

  // ==========================================================================
  // read path: data only in the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_addr)
      scbi_pkg::OFS_IRQ_MASK:    rd_mux = irq_mask;
      scbi_pkg::OFS_IRQ_STATUS:  rd_mux = irq_flags;
      scbi_pkg::OFS_PWR_STATUS:  rd_mux = pwr_status;
      scbi_pkg::OFS_SYSRC_TRIM:  rd_mux = 32'(o_sysrc_trim);
      scbi_pkg::OFS_SUPPLY_MON:  rd_mux = sm_ctrl;
      scbi_pkg::OFS_TEMP_SENSOR: rd_mux = {31'h0000_0000, o_temp_sensor_en};
      scbi_pkg::OFS_FAST_RC:     rd_mux = {31'h0000_0000, fast_rc_en};
      scbi_pkg::OFS_LOW_RC:      rd_mux = {31'h0000_0000, low_rc_en};
      default:                   rd_mux = hit_bk ? retained[bk_idx] : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // checks
  trim_fuse_a: assert property (@(posedge i_clk_sys) disable iff (!por_n)
    !trim_loaded |=> o_sysrc_trim == $past(i_fuse_trim))
    else $error("trim not loaded from fuse");

  trim_lock_a: assert property (@(posedge i_clk_sys) disable iff (!por_n)
    trim_loaded && !trim_wr |=> $stable(o_sysrc_trim))
    else $error("trim changed without unlock");

  access_err_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    prot_wr && !unlock_ok |=> irq_flags[scbi_pkg::BIT_AE])
    else $error("access error flag not set");

  bk_discard_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    i_wr && hit_bk && !bk_ready |=> $stable(retained[bk_idx]))
    else $error("retained write accepted while busy");

  bk_busy_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    bk_wr |=> (!bk_ready && !bk_valid)[*4] ##1 bk_ready && bk_valid)
    else $error("retained busy window wrong");

  flag_edge_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(i_brownout_detect) ##1 !wr_icr |=> irq_flags[scbi_pkg::BIT_BROWNOUT])
    else $error("edge flag not set");

  set_wins_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(i_regulator_ok) && wr_icr |=> irq_flags[scbi_pkg::BIT_REG_OK])
    else $error("clear beat coincident set");

  irq_mask_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    ~|(irq_flags & irq_mask) |=> !o_irq)
    else $error("irq without masked flag");

  mask_zero_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (wr_ier || wr_idr) && i_wdata == 32'h0000_0000 |=> $stable(irq_mask))
    else $error("zero write changed mask");

  low_rc_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    sm_sampling |=> o_low_rc_run)
    else $error("low rc stopped while sampling");

  static_off_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    i_sleep_mode == scbi_pkg::SLP_STATIC |=> !o_sysrc_run && !o_sysrc_ready)
    else $error("system rc running in static");

endmodule // scbi_top
`default_nettype wire

// file: tb/test_system_ctrl_backup_irq.sv
`timescale 1ns/1ps
`default_nettype none
module test_system_ctrl_backup_irq;
  // ==========================================================================
  // stimulus and observed signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        por_n = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  sleep = 3'h0;
  logic [7:0]  fuse = 8'h00;
  logic        fast_off = 1'b0;
  logic        pad_ctrl = 1'b1;
  logic        pad_func = 1'b1;
  logic        supply_low = 1'b0;
  logic        bod = 1'b0;
  logic        reg_ok = 1'b0;
  logic [7:0]  fll = 8'h00;
  logic        osc_rdy = 1'b0;
  logic        x32_rdy = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  trim;
  logic        irq, sys_run, sys_rdy, sm_pwr, sm_rst, lrc_run, lrc_pad, temp_sensor_ctrl, frc_run;
  logic        rd_seen = 1'b0;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  int          n_fail = 0;
  int          checks_done = 0;

  always #5 clk = ~clk;

  // status inputs start low so flag reads stay predictable
  scbi_top #(.LF_DIV(4), .SYSRC_START(5)) dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_por_n(por_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_sleep_mode(sleep), .i_fuse_trim(fuse),
    .i_pm_fast_rc_off(fast_off), .i_pm_pad_ctrl_rc_out(pad_ctrl), .i_pad_func_rc(pad_func),
    .i_supply_low(supply_low), .i_fll_status(fll), .i_brownout_detect(bod),
    .i_regulator_ok(reg_ok), .i_main_osc_ready(osc_rdy), .i_xtal32_ready(x32_rdy),
    .o_rdata(rdata), .o_irq(irq), .o_sysrc_run(sys_run), .o_sysrc_ready(sys_rdy),
    .o_sysrc_trim(trim), .o_sm_power(sm_pwr), .o_sm_reset_req(sm_rst),
    .o_low_rc_run(lrc_run), .o_low_rc_pad(lrc_pad), .o_temp_sensor_en(temp_sensor_ctrl),
    .o_fast_rc_run(frc_run));

  // ==========================================================================
  // compare tasks, bus tasks, read monitor
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic pin(input string what, input logic e, input logic g);
    check(what, {31'h0, e}, {31'h0, g});
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    q_exp.push_back(e & m);
    q_msk.push_back(m);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic pulse_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen && q_exp.size() > 0) begin
      check("rdata", q_exp[0], rdata & q_msk[0]);
      q_exp.delete(0);
      q_msk.delete(0);
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    int          k;
    logic [31:0] d;
    logic [7:0]  t;
    void'($urandom(32));
    fuse = 8'($urandom());
    t = 8'($urandom());
    d = $urandom();
    repeat (3) @(posedge clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    for (k = 0; k < 40 && sys_rdy !== 1'b1; k++) @(posedge clk);
    if (sys_rdy !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
    pin("sysrc_run", 1'b1, sys_run);
    pin("low_rc_run", 1'b1, lrc_run);
    pin("low_rc_pad", 1'b1, lrc_pad);
    check("trim", {24'h0, fuse}, {24'h0, trim});
    pad_ctrl <= 1'b0;
    wr_reg(scbi_pkg::OFS_IRQ_CLEAR, 32'hFFFF_FFFF);
    pin("low_rc_pad", 1'b0, lrc_pad);
    wr_reg(scbi_pkg::OFS_SYSRC_TRIM, {24'h0, ~fuse});
    rd_reg(scbi_pkg::OFS_SYSRC_TRIM, {24'h0, fuse}, 32'h0000_00FF);
    rd_reg(scbi_pkg::OFS_IRQ_STATUS, 32'h8000_0000, 32'h8000_0000);
    pin("irq", 1'b0, irq);
    wr_reg(scbi_pkg::OFS_UNLOCK, 32'hAA00_0048);
    wr_reg(scbi_pkg::OFS_SYSRC_TRIM, {24'h0, t});
    rd_reg(scbi_pkg::OFS_SYSRC_TRIM, {24'h0, t}, 32'h0000_00FF);
    wr_reg(scbi_pkg::OFS_IRQ_ENABLE, 32'h0000_0080);
    wr_reg(scbi_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
    wr_reg(scbi_pkg::OFS_IRQ_DISABLE, 32'h0000_0000);
    rd_reg(scbi_pkg::OFS_IRQ_MASK, 32'h0000_0080, 32'hFFFF_FFFF);
    bod <= 1'b1;
    repeat (4) @(posedge clk);
    pin("irq", 1'b1, irq);
    rd_reg(scbi_pkg::OFS_IRQ_STATUS, 32'h0000_0080, 32'h0000_0080);
    wr_reg(scbi_pkg::OFS_IRQ_CLEAR, 32'h0000_0080);
    repeat (2) @(posedge clk);
    pin("irq", 1'b0, irq);
    wr_reg(scbi_pkg::OFS_IRQ_DISABLE, 32'h0000_0080);
    rd_reg(scbi_pkg::OFS_IRQ_MASK, 32'h0000_0000, 32'hFFFF_FFFF);
    // status edges land in the same cycle as a clear write
    @(posedge clk);
    reg_ok <= 1'b1;
    fll <= 8'h01;
    x32_rdy <= 1'b1;
    wr <= 1'b1;
    addr <= scbi_pkg::OFS_IRQ_CLEAR;
    wdata <= 32'h0000_0121;
    @(posedge clk);
    wr <= 1'b0;
    rd_reg(scbi_pkg::OFS_IRQ_STATUS, 32'h0000_0121, 32'h0000_FFE3);
    // second retained write lands while the first is still busy
    @(posedge clk);
    wr <= 1'b1;
    addr <= scbi_pkg::OFS_RETAIN_0;
    wdata <= d;
    @(posedge clk);
    addr <= scbi_pkg::OFS_RETAIN_0 + 10'h004;
    wdata <= ~d;
    @(posedge clk);
    wr <= 1'b0;
    rd_reg(scbi_pkg::OFS_PWR_STATUS, 32'h0000_0000, 32'h0003_0000);
    repeat (6) @(posedge clk);
    rd_reg(scbi_pkg::OFS_PWR_STATUS, 32'h0003_0000, 32'h0003_0000);
    rd_reg(scbi_pkg::OFS_RETAIN_0, d, 32'hFFFF_FFFF);
    rd_reg(scbi_pkg::OFS_RETAIN_0 + 10'h004, 32'h0, 32'hFFFF_FFFF);
    wr_reg(scbi_pkg::OFS_RETAIN_0 + 10'h008, ~d);
    pulse_reset();
    rd_reg(scbi_pkg::OFS_PWR_STATUS, 32'h0000_0000, 32'h0002_0000);
    wr_reg(scbi_pkg::OFS_RETAIN_0 + 10'h00C, ~d);
    repeat (8) @(posedge clk);
    pulse_reset();
    rd_reg(scbi_pkg::OFS_PWR_STATUS, 32'h0002_0000, 32'h0002_0000);
    rd_reg(scbi_pkg::OFS_RETAIN_0 + 10'h00C, ~d, 32'hFFFF_FFFF);
    rd_reg(scbi_pkg::OFS_RETAIN_0, d, 32'hFFFF_FFFF);
    wr_reg(scbi_pkg::OFS_TEMP_SENSOR, 32'h0000_0001);
    wr_reg(scbi_pkg::OFS_FAST_RC, 32'h0000_0001);
    wr_reg(scbi_pkg::OFS_LOW_RC, 32'h0000_0000);
    repeat (2) @(posedge clk);
    pin("temp_en", 1'b1, temp_sensor_ctrl);
    pin("fast_rc", 1'b1, frc_run);
    fast_off <= 1'b1;
    sleep <= scbi_pkg::SLP_STATIC;
    repeat (4) @(posedge clk);
    pin("fast_rc", 1'b0, frc_run);
    pin("sysrc_run", 1'b0, sys_run);
    pin("low_rc_run", 1'b1, lrc_run);
    fast_off <= 1'b0;
    sleep <= scbi_pkg::SLP_RUN;
    repeat (4) @(posedge clk);
    pin("low_rc_run", 1'b0, lrc_run);
    wr_reg(scbi_pkg::OFS_FAST_RC, 32'h0000_0000);
    repeat (2) @(posedge clk);
    pin("fast_rc", 1'b0, frc_run);
    wr_reg(scbi_pkg::OFS_UNLOCK, 32'hAA00_004C);
    wr_reg(scbi_pkg::OFS_SUPPLY_MON, 32'h0000_0005);
    supply_low <= 1'b1;
    repeat (4) @(posedge clk);
    pin("sm_reset", 1'b1, sm_rst);
    supply_low <= 1'b0;
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule // test_system_ctrl_backup_irq
`default_nettype wire
